// [include/bus_ready_pkg.sv]
package bus_ready_pkg;
  // phase counter width; access phase programmable 1 to 32 cycles
  localparam int unsigned PHASE_W     = 6;
  localparam logic [5:0]  PHASE_ONE   = 6'h01;
  localparam logic [5:0]  PHASE_ZERO  = 6'h00;
  localparam logic [5:0]  ACC_MIN     = 6'h01;
  localparam logic [5:0]  ACC_MAX     = 6'h20;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned SYNC_STAGES = 2;
  // clock figures
  localparam int unsigned CLK_PERIOD_NS = 50;

  typedef enum logic [3:0]
  {
    ST_IDLE   = 4'h1,
    ST_ACCESS = 4'h2,
    ST_READY  = 4'h4,
    ST_END    = 4'h8
  } bus_state_t;
endpackage

// [src/ready_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for the asynchronous ready pin
module ready_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and synchronised level out
  input  wire logic level_in,
  output var  logic level_out
);
  logic meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r    <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      meta_r    <= level_in;
      level_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [src/bus_ready_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
// How it works
// - external ready pin lengthens cycles; its active level is configurable
// - synchronous mode samples ready directly; partner drives it on clock
// - asynchronous mode adds a two-stage synchroniser, costing at least two waits
// - first sampling point follows the programmed access phase length
// - ready inactive at a sample adds one ready wait state
// - ready active at a sample ends the running cycle
// - async sampling point lies later by the synchroniser latency
// - ready ignored until mandatory access wait states have elapsed
// - read data captured on the strobe-ending edge, later changes ignored
module bus_ready_ctrl
  import bus_ready_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // reference clock driven to the pins
  output var  logic                         reference_clock_output,
  // cycle request from the bus controller
  input  wire logic                         start,
  input  wire logic                         is_read,
  input  wire logic [bus_ready_pkg::PHASE_W-1:0] access_phase_length,
  input  wire logic                         ready_enable,
  input  wire logic                         ready_async,
  input  wire logic                         ready_active_high,
  // external pins
  input  wire logic                         ready_pin,
  input  wire logic [bus_ready_pkg::DATA_W-1:0]  data_pin,
  output var  logic                         strobe_n,
  // results to the bus controller
  output var  logic                         busy,
  output var  logic                         ready_wait_state,
  output var  logic                         cycle_done,
  output var  logic [bus_ready_pkg::DATA_W-1:0]  read_data
);
  import bus_ready_pkg::*;

  // hold count that delays the asynchronous sample by the synchroniser depth
  localparam logic [PHASE_W-1:0] SYNC_HOLD = PHASE_W'(SYNC_STAGES);

  bus_state_t               state_r;
  bus_state_t               state_nxt;
  logic [PHASE_W-1:0]       count_r;
  logic [PHASE_W-1:0]       count_nxt;
  logic                     async_r;
  logic                     renable_r;
  logic                     rpol_r;
  logic                     read_r;
  logic                     ready_synced;
  logic                     done_r;
  logic                     wait_r;
  logic [DATA_W-1:0]        rdata_r;

  // clamp the programmed access length into its legal span
  function automatic logic [PHASE_W-1:0] clamp_len(input logic [PHASE_W-1:0] l);
    if (l < ACC_MIN)
      return ACC_MIN;
    else if (l > ACC_MAX)
      return ACC_MAX;
    else
      return l;
  endfunction

  // extra synchroniser path for the asynchronous mode
  ready_sync u_sync
  (
    .clk       (clk),
    .rst       (rst),
    .level_in  (ready_pin),
    .level_out (ready_synced)
  );

  // decode: raw or synchronised sample, polarity applied
  wire ready_src  = async_r ? ready_synced : ready_pin;
  wire ready_act  = (ready_src == rpol_r);
  wire phase_last = (count_r == PHASE_ONE);
  wire in_access  = (state_r == ST_ACCESS);
  wire in_ready   = (state_r == ST_READY);
  wire ready_open = in_ready && (count_r == PHASE_ZERO);
  wire ready_hit  = ready_open && ready_act;
  wire end_now    = (in_access && phase_last && !renable_r)
                  || ready_hit;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start)
        begin
          state_nxt = ST_ACCESS;
          count_nxt = clamp_len(access_phase_length);
        end
      end
      ST_ACCESS:
      begin
        if (!phase_last)
          count_nxt = count_r - PHASE_ONE;
        else if (!renable_r)
          state_nxt = ST_END;
        else
        begin
          state_nxt = ST_READY;
          count_nxt = async_r ? SYNC_HOLD : PHASE_ZERO;
        end
      end
      ST_READY:
      begin
        // async mode waits out the synchroniser before the first real sample
        if (count_r != PHASE_ZERO)
          count_nxt = count_r - PHASE_ONE;
        else if (ready_act)
          state_nxt = ST_END;
        else
          state_nxt = ST_READY;
      end
      ST_END:
      begin
        state_nxt = ST_IDLE;
        count_nxt = PHASE_ZERO;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        count_nxt = PHASE_ZERO;
      end
    endcase
  end

  // state, latched cycle options
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r   <= ST_IDLE;
      count_r   <= PHASE_ZERO;
      async_r   <= 1'b0;
      renable_r <= 1'b0;
      rpol_r    <= 1'b0;
      read_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      if (state_r == ST_IDLE && start)
      begin
        async_r   <= ready_async;
        renable_r <= ready_enable;
        rpol_r    <= ready_active_high;
        read_r    <= is_read;
      end
    end
  end

  // status flags and read capture on the strobe-ending edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_r  <= 1'b0;
      wait_r  <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      done_r <= end_now;
      wait_r <= in_ready && !ready_hit;
      if (end_now && read_r)
        rdata_r <= data_pin;
    end
  end

  // outputs; reference clock mirrors the system clock
  assign reference_clock_output = clk;
  assign strobe_n         = !(in_access || in_ready);
  assign busy             = (state_r != ST_IDLE);
  assign cycle_done       = done_r;
  assign ready_wait_state = wait_r;
  assign read_data        = rdata_r;

  // ready wait never follows a non-ready cycle
  no_rdy_wait_a: assert property (@(posedge clk) disable iff (rst)
    (in_access && phase_last && !renable_r) |=> (state_r == ST_END))
    else $error("cycle without ready control did not end");

  ready_end_a: assert property (@(posedge clk) disable iff (rst)
    ready_hit |=> (state_r == ST_END) && cycle_done)
    else $error("active ready did not end the cycle");

  not_ready_a: assert property (@(posedge clk) disable iff (rst)
    (ready_open && !ready_act) |=> (in_ready && ready_wait_state))
    else $error("inactive ready did not add a wait state");

  access_len_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_IDLE && start && access_phase_length == 6'h03)
    |=> in_access [*3] ##1 !in_access)
    else $error("access phase length wrong");

  no_early_end_a: assert property (@(posedge clk) disable iff (rst)
    (in_access && !phase_last) |=> !cycle_done && !(state_r == ST_END))
    else $error("cycle ended inside access phase");

  read_cap_a: assert property (@(posedge clk) disable iff (rst)
    (end_now && read_r) |=> (read_data == $past(data_pin)))
    else $error("read data not captured at cycle end");

  async_lat_a: assert property (@(posedge clk) disable iff (rst)
    (in_ready && async_r && $rose(ready_synced) && rpol_r)
    |-> $past(ready_pin, 2))
    else $error("async ready path latency wrong");

  polarity_a: assert property (@(posedge clk) disable iff (rst)
    (in_ready && !async_r && (ready_pin != rpol_r)) |=> in_ready)
    else $error("ready polarity not honoured");

  async_wait_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(in_ready) && async_r) |=> in_ready [*2])
    else $error("async ready cycle ended without wait states");
endmodule
`default_nettype wire

// [testbench/ready_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module ready_partner
(
  // reference clock and command strobe from the block
  input  wire logic        ref_clk,
  input  wire logic        strobe_n,
  // behaviour chosen by the bench
  input  wire logic        active_high,
  input  wire logic [7:0]  wait_cycles,
  input  wire logic [15:0] word,
  // pins back to the block
  output var  logic        ready_pin,
  output var  logic [15:0] data_pin
);
  logic [7:0] cnt_r = 8'h00;
  logic       rdy_r = 1'b0;
  logic       rdy;
  // count strobe-low cycles, ready moves only on the reference clock
  always_ff @(posedge ref_clk)
  begin
    cnt_r <= strobe_n ? 8'h00 : cnt_r + 8'h01;
    rdy_r <= !strobe_n && cnt_r >= wait_cycles;
  end
  // ready dropped with the trailing strobe edge, level per polarity
  assign rdy = rdy_r && !strobe_n;
  assign ready_pin = (rdy == active_high);
  // a released data bus shows the inverse of the word
  assign data_pin = strobe_n ? ~word : word;
endmodule
`default_nettype wire

// [testbench/external_bus_ready_wait_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module external_bus_ready_wait_control_tb;
  import bus_ready_pkg::*;
  logic        clk, rst, start, is_read, ready_enable, ready_async;
  logic        ready_active_high, ready_pin, strobe_n, busy, ref_clk;
  logic        ready_wait_state, cycle_done;
  logic [5:0]  access_phase_length;
  logic [7:0]  wait_cycles;
  logic [15:0] word, data_pin, read_data, last;
  int          miscompares, n_checks;
  int          cyc = 0;
  // clock generator
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  bus_ready_ctrl dut (.clk(clk), .rst(rst), .reference_clock_output(ref_clk),
    .start(start), .is_read(is_read), .access_phase_length(access_phase_length),
    .ready_enable(ready_enable), .ready_async(ready_async),
    .ready_active_high(ready_active_high), .ready_pin(ready_pin),
    .data_pin(data_pin), .strobe_n(strobe_n), .busy(busy),
    .ready_wait_state(ready_wait_state), .cycle_done(cycle_done),
    .read_data(read_data));
  ready_partner mem (.ref_clk(ref_clk), .strobe_n(strobe_n),
    .active_high(ready_active_high), .wait_cycles(wait_cycles), .word(word),
    .ready_pin(ready_pin), .data_pin(data_pin));
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one bus cycle entered at a falling edge; length counted in edges
  task automatic run(input logic rd, en, as, ah, input logic [5:0] len,
                     input logic [7:0] w, input logic [15:0] d);
    int n;
    int e;
    int k;
    int x;
    int wt;
    n = (len == 6'h00) ? 1 : (len > 6'h20) ? 32 : int'(len);
    k = en ? ((w + 1 > n) ? w + 1 - n : 0) + (as ? 2 : 0) : 0;
    x = n + (en ? 2 + k : 1);
    {is_read, ready_enable, ready_async, ready_active_high} = {rd, en, as, ah};
    access_phase_length = len;
    wait_cycles = w;
    word = d;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("strobe in cycle", 16'h0000, {15'h0000, strobe_n});
    e = 1;
    wt = 0;
    while (cycle_done !== 1'b1 && e < 200)
    begin
      @(negedge clk);
      e++;
      if (ready_wait_state === 1'b1)
        wt++;
    end
    chk("cycle length", 16'(x), 16'(e));
    chk("ready waits", 16'(k), 16'(wt));
    if (rd)
      last = d;
    chk("read data", last, read_data);
    @(negedge clk);
    chk("busy after end", 16'h0000, {15'h0000, busy});
    chk("strobe after end", 16'h0001, {15'h0000, strobe_n});
    chk("done pulse", 16'h0000, {15'h0000, cycle_done});
    chk("reference clock", {15'h0000, clk}, {15'h0000, ref_clk});
  endtask
  // synchronous ready: first sample, waits, early ready ignored, polarity
  task automatic t_sync();
    run(1'b1,1'b1,1'b0,1'b1,6'h01,8'h00,16'ha5c3);
    run(1'b1,1'b1,1'b0,1'b0,6'h04,8'h06,16'h3c5a);
    run(1'b1,1'b1,1'b0,1'b1,6'h04,8'h00,16'h0ff0);
    $display("test sync finished");
  endtask
  // asynchronous ready pays the synchroniser latency
  task automatic t_async();
    run(1'b1,1'b1,1'b1,1'b0,6'h01,8'h00,16'h1234);
    run(1'b1,1'b1,1'b1,1'b1,6'h01,8'h02,16'h8001);
    run(1'b1,1'b1,1'b1,1'b1,6'h04,8'h00,16'h6b6b);
    $display("test async finished");
  endtask
  // ready off: phases alone, ready never given, length clamps
  task automatic t_noready();
    run(1'b1,1'b0,1'b0,1'b1,6'h20,8'hff,16'h5555);
    run(1'b1,1'b0,1'b1,1'b1,6'h00,8'hff,16'haaaa);
    run(1'b1,1'b0,1'b0,1'b0,6'h28,8'hff,16'h7e7e);
    $display("test no ready finished");
  endtask
  // a write leaves the captured read word alone
  task automatic t_write();
    run(1'b0,1'b1,1'b0,1'b1,6'h02,8'h03,16'hdead);
    $display("test write finished");
  endtask
  // reset in mid-cycle returns the block to idle; a read follows at once
  task automatic t_reset();
    {is_read, ready_enable, ready_async} = 3'h4;
    access_phase_length = 6'h10;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    last = 16'h0000;
    chk("busy after reset", 16'h0000, {15'h0000, busy});
    chk("strobe after reset", 16'h0001, {15'h0000, strobe_n});
    chk("done after reset", 16'h0000, {15'h0000, cycle_done});
    chk("waits after reset", 16'h0000,
        {15'h0000, ready_wait_state});
    chk("read data after reset", last, read_data);
    run(1'b1,1'b1,1'b0,1'b1,6'h03,8'h01,16'h4b2d);
    $display("test reset finished");
  endtask
  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // main sequence
  initial
  begin
    {rst, start, is_read, ready_enable, ready_async} = 5'h10;
    ready_active_high = 1'b1;
    access_phase_length = 6'h01;
    wait_cycles = 8'h00;
    word = 16'h0000;
    last = 16'h0000;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("read data at reset", 16'h0000, read_data);
    t_sync();
    t_async();
    t_noready();
    t_write();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
